// *** refclk_pkg.sv ***
// Shared constants, types and register layout of the reference clock output block
`default_nettype none
package refclk_pkg;

    // Register byte offsets
    localparam logic [7:0] REF_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] OSC_CFG_OFFSET = 8'h04;
    localparam logic [7:0] CLK_STATUS_OFFSET = 8'h08;

    // Reference control register field positions
    localparam int REF_EN_BIT = 15;
    localparam int REF_SLEEP_RUN_BIT = 13;
    localparam int REF_SRC_SEL_BIT = 12;
    localparam int REF_DIV_LSB = 8;
    localparam int REF_DIV_W = 4;

    // Oscillator configuration register field positions
    localparam int OSC_MODE_LSB = 0;
    localparam int RC_POST_LSB = 4;
    localparam int POSC_KEEP_BIT = 8;
    localparam int SELF_TUNE_BIT = 9;
    localparam int RC_TUNE_LSB = 16;
    localparam int RC_TUNE_W = 6;

    // Status register bit positions
    localparam int ST_USB_OK_BIT = 0;
    localparam int ST_SYS_RUN_BIT = 1;
    localparam int ST_POSC_EN_BIT = 2;
    localparam int ST_REF_ACT_BIT = 3;
    localparam int ST_ASLEEP_BIT = 4;
    localparam int ST_HALF_ACT_BIT = 5;

    // Fast RC postscaler codes allowed for USB
    localparam logic [2:0] RC_POST_8MHZ = 3'h0;
    localparam logic [2:0] RC_POST_4MHZ = 3'h1;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Oscillator modes
    typedef enum logic [2:0] {
        fast_internal_rc_osc = 3'h0,
        fast_rc_with_pll_mode = 3'h1,
        external_clock_mode = 3'h2,
        standard_crystal_mode = 3'h3,
        high_speed_crystal_mode = 3'h4,
        external_clock_pll_mode = 3'h5,
        standard_crystal_pll_mode = 3'h6,
        high_speed_crystal_pll_mode = 3'h7
    } osc_mode_t;

    // Sleep sequencer, Gray coded along RUN-ENTER-SLEEP-WAKE
    typedef enum logic [1:0] {
        PWR_RUN = 2'h0,
        PWR_ENTER = 2'h1,
        PWR_SLEEP = 2'h3,
        PWR_WAKE = 2'h2
    } pwr_state_t;

    typedef struct packed {
        logic enable;
        logic run_in_sleep;
        logic source_select;
        logic [REF_DIV_W-1:0] divider_select;
    } ref_ctrl_t;

    typedef struct packed {
        osc_mode_t mode;
        logic [2:0] rc_postscaler;
        logic keep_in_sleep;
        logic self_tune;
        logic [RC_TUNE_W-1:0] rc_tune;
    } osc_cfg_t;

    localparam ref_ctrl_t REF_CTRL_RESET = '{1'b0, 1'b0, 1'b0, 4'h0};
    localparam osc_cfg_t OSC_CFG_RESET = '{fast_internal_rc_osc, 3'h0, 1'b0, 1'b0, 6'h00};

endpackage
`default_nettype wire

// *** refclk_divider.sv ***
// Divider that derives the reference output from a sampled clock level
`timescale 1ns/100ps
`default_nettype none
module refclk_divider
    import refclk_pkg::*;
#(
    parameter int CODE_W = REF_DIV_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic run,
    input wire logic src_level,
    input wire logic [CODE_W-1:0] code,
    output logic div_out
);
    localparam int CNT_W = (1 << CODE_W) - 1;

    logic src_prev_ff, nxt_src_prev;
    logic [CNT_W-1:0] count_ff, nxt_count;
    logic out_ff, nxt_out;

    // Source edges, less one, needed before each output toggle
    function automatic logic [CNT_W-1:0] half_limit(input logic [CODE_W-1:0] c);
        logic [CNT_W-1:0] one;
        one = {{(CNT_W-1){1'b0}}, 1'b1};
        half_limit = (one << (c - 1'b1)) - one;
    endfunction

    initial begin
        if (CODE_W < 1 || CODE_W > 5) begin
            $error("refclk_divider: CODE_W out of range");
        end
    end

    // Code 0 passes the source, code n divides by 2**n
    always_comb begin
        nxt_src_prev = src_level;
        nxt_count = count_ff;
        nxt_out = out_ff;
        if (!run) begin
            nxt_count = '0;
            nxt_out = 1'b0;
        end else if (code == '0) begin // R15
            nxt_out = src_level;
            nxt_count = '0;
        end else if (src_level && !src_prev_ff) begin
            if (count_ff >= half_limit(code)) begin // R2
                nxt_count = '0;
                nxt_out = !out_ff;
            end else begin
                nxt_count = count_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src_prev_ff <= 1'b0;
            count_ff <= '0;
            out_ff <= 1'b0;
        end else if (ce) begin
            src_prev_ff <= nxt_src_prev;
            count_ff <= nxt_count;
            out_ff <= nxt_out;
        end
    end

    assign div_out = out_ff;
endmodule
`default_nettype wire

// *** refclk_top.sv ***
// Reference clock output, half-rate clock out and USB clock qualification
// What this block does
// R1: Enable bit 15 of reference control drives the selected clock onto ref_clock_pin.
// R2: Four-bit divider field at bits 11:8 picks one of sixteen ratios.
// R3: Source select picks primary oscillator pins or current system clock.
// R4: Sleep-run bit decides whether reference output continues during Sleep.
// R5: Sleep output needs both sleep-run and source select set by software.
// R6: Sleep stops primary oscillator unless primary mode or keep bit set.
// R7: With source select clear, output follows system clock through clock switches.
// R8: Certain modes give a fixed half-rate clock on half_rate_clock_out_pin.
// R9: Reference output works in every oscillator configuration.
// R10: USB is clocked only from permitted modes, never a separate source.
// R11: Software sets fast RC postscaler to 000 or 001 and matches PLL.
// R12: Software should use self-tune or tune field for USB accuracy.
// R13: Other modes stay selectable but USB clock is then off.
// R14: Sleep shuts down the system clock and its on-chip oscillator.
// R15: Divider code zero passes source undivided; larger codes divide more.
`timescale 1ns/100ps
`default_nettype none
module refclk_top
    import refclk_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic SLEEP_REQ,
    input wire logic PRIMARY_OSC_IN,
    input wire logic FAST_RC_OSC_IN,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic REF_CLOCK_PIN,
    output logic REF_CLOCK_PIN_OE,
    output logic HALF_RATE_CLOCK_OUT_PIN,
    output logic HALF_RATE_CLOCK_OUT_PIN_OE,
    output logic PRIMARY_OSC_EN,
    output logic FAST_RC_OSC_EN,
    output logic SYS_CLOCK_RUN,
    output logic USB_CLOCK_EN,
    output logic [RC_TUNE_W-1:0] FRC_TUNE,
    output logic FRC_SELF_TUNE_EN
);
    initial begin
        if (ADDR_W < 4 || ADDR_W > 32) begin
            $error("refclk_top: ADDR_W out of range");
        end
    end

    // Modes that run from the primary oscillator pins
    function automatic logic is_primary(input osc_mode_t m);
        is_primary = (m != fast_internal_rc_osc) && (m != fast_rc_with_pll_mode);
    endfunction

    // Modes whose clock-out pin is free for the half-rate clock
    function automatic logic has_half_rate(input osc_mode_t m);
        has_half_rate = (m == fast_internal_rc_osc) || (m == fast_rc_with_pll_mode) ||
            (m == external_clock_mode) || (m == external_clock_pll_mode);
    endfunction

    // Only PLL modes may clock USB; fast RC needs 4 or 8 MHz postscaling
    function automatic logic usb_permitted(input osc_cfg_t c);
        unique case (c.mode)
            fast_rc_with_pll_mode: usb_permitted = (c.rc_postscaler == RC_POST_8MHZ) ||
                (c.rc_postscaler == RC_POST_4MHZ);
            external_clock_pll_mode, standard_crystal_pll_mode, high_speed_crystal_pll_mode:
                usb_permitted = 1'b1;
            fast_internal_rc_osc, external_clock_mode, standard_crystal_mode, high_speed_crystal_mode:
                usb_permitted = 1'b0;
        endcase
    endfunction

    // Word match of a bus address; any bit above the register block makes it miss
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        addr_hit = (32'(a) >> 2) == (32'(off) >> 2);
    endfunction

    // Byte-lane merge of a bus write into a register word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[8*i +: 8] = data[8*i +: 8];
            end
        end
    endfunction

    function automatic logic [31:0] ctrl_word(input ref_ctrl_t r);
        ctrl_word = 32'h0000_0000;
        ctrl_word[REF_EN_BIT] = r.enable;
        ctrl_word[REF_SLEEP_RUN_BIT] = r.run_in_sleep;
        ctrl_word[REF_SRC_SEL_BIT] = r.source_select;
        ctrl_word[REF_DIV_LSB +: REF_DIV_W] = r.divider_select;
    endfunction

    function automatic logic [31:0] cfg_word(input osc_cfg_t c);
        cfg_word = 32'h0000_0000;
        cfg_word[OSC_MODE_LSB +: 3] = c.mode;
        cfg_word[RC_POST_LSB +: 3] = c.rc_postscaler;
        cfg_word[POSC_KEEP_BIT] = c.keep_in_sleep;
        cfg_word[SELF_TUNE_BIT] = c.self_tune;
        cfg_word[RC_TUNE_LSB +: RC_TUNE_W] = c.rc_tune;
    endfunction

    // Pin synchronisers, stage one feeds stage two only
    logic posc_s1_ff, posc_s2_ff, frc_s1_ff, frc_s2_ff;
    logic frc_s3_ff, nxt_frc_s3;
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            posc_s1_ff <= 1'b0;
            posc_s2_ff <= 1'b0;
            frc_s1_ff <= 1'b0;
            frc_s2_ff <= 1'b0;
        end else if (CE) begin
            posc_s1_ff <= PRIMARY_OSC_IN;
            posc_s2_ff <= posc_s1_ff;
            frc_s1_ff <= FAST_RC_OSC_IN;
            frc_s2_ff <= frc_s1_ff;
        end
    end

    // Registers and bus state
    ref_ctrl_t ref_ctrl_ff, nxt_ref_ctrl;
    osc_cfg_t osc_cfg_ff, nxt_osc_cfg;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
    logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
    logic [31:0] w_data_ff, nxt_w_data;
    logic [3:0] w_strb_ff, nxt_w_strb;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic arready_ff, nxt_arready, ar_hold_ff, nxt_ar_hold;
    logic [ADDR_W-1:0] ar_addr_ff, nxt_ar_addr;
    logic rvalid_ff, nxt_rvalid;
    logic [1:0] rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [31:0] status_word, ctrl_merged, cfg_merged;

    // Write channel: address and data taken in either order, then one response
    always_comb begin
        ctrl_merged = merge(ctrl_word(ref_ctrl_ff), w_data_ff, w_strb_ff);
        cfg_merged = merge(cfg_word(osc_cfg_ff), w_data_ff, w_strb_ff);
        nxt_ref_ctrl = ref_ctrl_ff;
        nxt_osc_cfg = osc_cfg_ff;
        nxt_aw_hold = aw_hold_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_hold = w_hold_ff;
        nxt_w_data = w_data_ff;
        nxt_w_strb = w_strb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (bvalid_ff && BREADY) begin
            nxt_bvalid = 1'b0;
        end
        if (AWVALID && awready_ff) begin
            nxt_aw_hold = 1'b1;
            nxt_aw_addr = AWADDR;
        end
        if (WVALID && wready_ff) begin
            nxt_w_hold = 1'b1;
            nxt_w_data = WDATA;
            nxt_w_strb = WSTRB;
        end
        if (aw_hold_ff && w_hold_ff && !bvalid_ff) begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            if (addr_hit(aw_addr_ff, REF_CTRL_OFFSET)) begin
                nxt_ref_ctrl = '{ctrl_merged[REF_EN_BIT], ctrl_merged[REF_SLEEP_RUN_BIT],
                    ctrl_merged[REF_SRC_SEL_BIT], ctrl_merged[REF_DIV_LSB +: REF_DIV_W]}; // R1 R2 R3 R4
            end else if (addr_hit(aw_addr_ff, OSC_CFG_OFFSET)) begin
                nxt_osc_cfg = '{osc_mode_t'(cfg_merged[OSC_MODE_LSB +: 3]), cfg_merged[RC_POST_LSB +: 3],
                    cfg_merged[POSC_KEEP_BIT], cfg_merged[SELF_TUNE_BIT], cfg_merged[RC_TUNE_LSB +: RC_TUNE_W]};
            end else if (!addr_hit(aw_addr_ff, CLK_STATUS_OFFSET)) begin
                nxt_bresp = RESP_SLVERR;
            end
        end
        nxt_awready = !nxt_aw_hold;
        nxt_wready = !nxt_w_hold;
    end

    // Read channel: one read at a time, data two cycles after the address
    always_comb begin
        nxt_ar_hold = ar_hold_ff;
        nxt_ar_addr = ar_addr_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        if (rvalid_ff && RREADY) begin
            nxt_rvalid = 1'b0;
        end
        if (ARVALID && arready_ff) begin
            nxt_ar_hold = 1'b1;
            nxt_ar_addr = ARADDR;
        end
        if (ar_hold_ff && !rvalid_ff) begin
            nxt_ar_hold = 1'b0;
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            nxt_rdata = 32'h0000_0000;
            if (addr_hit(ar_addr_ff, REF_CTRL_OFFSET)) begin
                nxt_rdata = ctrl_word(ref_ctrl_ff);
            end else if (addr_hit(ar_addr_ff, OSC_CFG_OFFSET)) begin
                nxt_rdata = cfg_word(osc_cfg_ff);
            end else if (addr_hit(ar_addr_ff, CLK_STATUS_OFFSET)) begin
                nxt_rdata = status_word;
            end else begin
                nxt_rresp = RESP_SLVERR;
            end
        end
        nxt_arready = !nxt_ar_hold;
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ref_ctrl_ff <= REF_CTRL_RESET;
            osc_cfg_ff <= OSC_CFG_RESET;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_hold_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_hold_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            arready_ff <= 1'b1;
            ar_hold_ff <= 1'b0;
            ar_addr_ff <= '0;
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else if (CE) begin
            ref_ctrl_ff <= nxt_ref_ctrl;
            osc_cfg_ff <= nxt_osc_cfg;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            aw_hold_ff <= nxt_aw_hold;
            aw_addr_ff <= nxt_aw_addr;
            w_hold_ff <= nxt_w_hold;
            w_data_ff <= nxt_w_data;
            w_strb_ff <= nxt_w_strb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            ar_hold_ff <= nxt_ar_hold;
            ar_addr_ff <= nxt_ar_addr;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
        end
    end

    // Sleep sequencer
    pwr_state_t pwr_ff, nxt_pwr;
    logic asleep;
    always_comb begin
        nxt_pwr = pwr_ff;
        unique case (pwr_ff)
            PWR_RUN: if (SLEEP_REQ) nxt_pwr = PWR_ENTER;
            PWR_ENTER: nxt_pwr = PWR_SLEEP;
            PWR_SLEEP: if (!SLEEP_REQ) nxt_pwr = PWR_WAKE;
            PWR_WAKE: nxt_pwr = PWR_RUN;
        endcase
    end
    assign asleep = (pwr_ff == PWR_ENTER) || (pwr_ff == PWR_SLEEP);

    // Clock sources, oscillator enables and source selection
    logic posc_on, frc_on, sys_level, ref_src, ref_run, half_ok, usb_ok;
    logic half_ff, nxt_half, ref_div;
    always_comb begin
        posc_on = !asleep || is_primary(osc_cfg_ff.mode) || osc_cfg_ff.keep_in_sleep; // R6
        frc_on = !asleep; // R14
        sys_level = asleep ? 1'b0 :
            (is_primary(osc_cfg_ff.mode) ? posc_s2_ff : frc_s2_ff); // R14
        ref_src = ref_ctrl_ff.source_select ? (posc_on && posc_s2_ff) : sys_level; // R3 R7
        ref_run = ref_ctrl_ff.enable &&
            (!asleep || (ref_ctrl_ff.run_in_sleep && ref_ctrl_ff.source_select && posc_on)); // R4 R5 R9
        half_ok = has_half_rate(osc_cfg_ff.mode) && !asleep; // R8
        usb_ok = usb_permitted(osc_cfg_ff); // R10 R11 R13
        nxt_frc_s3 = sys_level;
        nxt_half = half_ff;
        if (!half_ok) begin
            nxt_half = 1'b0;
        end else if (sys_level && !frc_s3_ff) begin
            nxt_half = !half_ff; // R8
        end
    end

    refclk_divider #(
        .CODE_W(REF_DIV_W)
    ) u_divider (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .ce(CE),
        .run(ref_run),
        .src_level(ref_src),
        .code(ref_ctrl_ff.divider_select),
        .div_out(ref_div)
    );

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_USB_OK_BIT] = usb_ok;
        status_word[ST_SYS_RUN_BIT] = !asleep;
        status_word[ST_POSC_EN_BIT] = posc_on;
        status_word[ST_REF_ACT_BIT] = ref_run;
        status_word[ST_ASLEEP_BIT] = asleep;
        status_word[ST_HALF_ACT_BIT] = half_ok;
    end

    // Registered pin and enable outputs
    logic ref_pin_ff, ref_oe_ff, half_oe_ff, posc_en_ff, frc_en_ff, sys_run_ff, usb_en_ff;
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            pwr_ff <= PWR_RUN;
            frc_s3_ff <= 1'b0;
            half_ff <= 1'b0;
            ref_pin_ff <= 1'b0;
            ref_oe_ff <= 1'b0;
            half_oe_ff <= 1'b0;
            posc_en_ff <= 1'b0;
            frc_en_ff <= 1'b0;
            sys_run_ff <= 1'b0;
            usb_en_ff <= 1'b0;
        end else if (CE) begin
            pwr_ff <= nxt_pwr;
            frc_s3_ff <= nxt_frc_s3;
            half_ff <= nxt_half;
            ref_pin_ff <= ref_div && ref_run; // R1
            ref_oe_ff <= ref_ctrl_ff.enable; // R1
            half_oe_ff <= has_half_rate(osc_cfg_ff.mode); // R8
            posc_en_ff <= posc_on; // R6
            frc_en_ff <= frc_on; // R14
            sys_run_ff <= !asleep; // R14
            usb_en_ff <= usb_ok && !asleep; // R10 R13
        end
    end

    assign AWREADY = awready_ff;
    assign WREADY = wready_ff;
    assign BVALID = bvalid_ff;
    assign BRESP = bresp_ff;
    assign ARREADY = arready_ff;
    assign RVALID = rvalid_ff;
    assign RRESP = rresp_ff;
    assign RDATA = rdata_ff;
    assign REF_CLOCK_PIN = ref_pin_ff;
    assign REF_CLOCK_PIN_OE = ref_oe_ff;
    assign HALF_RATE_CLOCK_OUT_PIN = half_ff;
    assign HALF_RATE_CLOCK_OUT_PIN_OE = half_oe_ff;
    assign PRIMARY_OSC_EN = posc_en_ff;
    assign FAST_RC_OSC_EN = frc_en_ff;
    assign SYS_CLOCK_RUN = sys_run_ff;
    assign USB_CLOCK_EN = usb_en_ff;
    assign FRC_TUNE = osc_cfg_ff.rc_tune; // R12
    assign FRC_SELF_TUNE_EN = osc_cfg_ff.self_tune; // R12
endmodule
`default_nettype wire

// *** refclk_sva.sv ***
// Port checker for the reference clock output block
`timescale 1ns/100ps
`default_nettype none
module refclk_sva (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic SLEEP_REQ,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [1:0] BRESP,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [31:0] RDATA,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic REF_CLOCK_PIN,
    input wire logic REF_CLOCK_PIN_OE,
    input wire logic HALF_RATE_CLOCK_OUT_PIN,
    input wire logic HALF_RATE_CLOCK_OUT_PIN_OE,
    input wire logic SYS_CLOCK_RUN,
    input wire logic USB_CLOCK_EN
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B || !CE);
    logic [4:0] stall_ff;
    logic [4:0] nxt_stall;
    logic half_ff;
    // Cycles the half-rate pin has sat still while it should run
    always_comb begin
        nxt_stall = 5'h00;
        if (HALF_RATE_CLOCK_OUT_PIN_OE && SYS_CLOCK_RUN && HALF_RATE_CLOCK_OUT_PIN == half_ff && stall_ff != 5'h1F) begin
            nxt_stall = stall_ff + 5'h01;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            stall_ff <= 5'h00;
            half_ff <= 1'b0;
        end else if (CE) begin
            stall_ff <= nxt_stall;
            half_ff <= HALF_RATE_CLOCK_OUT_PIN;
        end
    end
    sequence sleep_held;
        (SLEEP_REQ && CE) [*4];
    endsequence
    sequence wr_taken;
        AWVALID && AWREADY && WVALID && WREADY;
    endsequence
    chk_half_rate_runs: assert property (stall_ff <= 5'h10) else $error("half-rate pin stuck");
    chk_pin_idle_off: assert property (!REF_CLOCK_PIN_OE [*3] |-> !REF_CLOCK_PIN) else $error("ref pin active");
    chk_usb_sleep_off: assert property (sleep_held |-> !USB_CLOCK_EN) else $error("usb clock in sleep");
    chk_sys_sleep_off: assert property (sleep_held |-> !SYS_CLOCK_RUN) else $error("sys clock in sleep");
    chk_b_holds: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("write reply dropped");
    chk_r_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read reply dropped");
    chk_write_answer: assert property (wr_taken |-> ##[1:2] BVALID) else $error("no write reply");
    chk_read_answer: assert property (ARVALID && ARREADY |-> ##[1:2] RVALID) else $error("no read reply");
endmodule
`default_nettype wire

// *** ref_clock_sink.sv ***
// Board device that counts reference clock edges on its input
`timescale 1ns/100ps
`default_nettype none
module ref_clock_sink (
    input wire logic clk,
    input wire logic clr,
    input wire logic pin,
    input wire logic pin_oe,
    output int unsigned edges
);
    logic last;
    // Only a driven pin clocks the device
    always @(posedge clk) begin
        if (clr) edges <= 0;
        else if (pin_oe && pin && !last) edges <= edges + 1;
        last <= pin;
    end
endmodule
`default_nettype wire

// *** reference_clock_output_test.sv ***
// Self-checking bench for the reference clock output block
`timescale 1ns/100ps
`default_nettype none
module reference_clock_output_test;
    import refclk_pkg::*;
    logic CLK_SYS = 1'b0, RST_B = 1'b0, CE = 1'b1, SLEEP_REQ = 1'b0, PRIMARY_OSC_IN = 1'b0, FAST_RC_OSC_IN = 1'b0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic [3:0] WSTRB = 4'hF;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0, clr = 1'b1;
    wire AWREADY, WREADY, BVALID, ARREADY, RVALID, REF_CLOCK_PIN, REF_CLOCK_PIN_OE, HALF_RATE_CLOCK_OUT_PIN;
    wire HALF_RATE_CLOCK_OUT_PIN_OE, PRIMARY_OSC_EN, FAST_RC_OSC_EN, SYS_CLOCK_RUN, USB_CLOCK_EN, FRC_SELF_TUNE_EN;
    wire [1:0] BRESP, RRESP;
    wire [31:0] RDATA;
    wire [5:0] FRC_TUNE;
    logic [2:0] pcnt = 3'h0;
    int unsigned edges;
    int err_count = 0, samples_checked = 0, code, sel, mode;
    refclk_top uut (.*);
    ref_clock_sink sink (.clk(CLK_SYS), .clr(clr), .pin(REF_CLOCK_PIN), .pin_oe(REF_CLOCK_PIN_OE), .edges(edges));
    always #10 CLK_SYS = ~CLK_SYS;
    // Oscillators stop when their enables drop
    always @(posedge CLK_SYS) begin
        pcnt <= pcnt + 3'h1;
        PRIMARY_OSC_IN <= pcnt[2] & PRIMARY_OSC_EN;
        FAST_RC_OSC_IN <= pcnt[1] & FAST_RC_OSC_EN;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge CLK_SYS);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
        end while (!BVALID);
        BREADY <= 1'b0;
        check(BRESP, er);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge CLK_SYS);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
        end while (!RVALID);
        RREADY <= 1'b0;
        check(RRESP, er);
        if (er === RESP_OKAY) check(RDATA, exp);
    endtask
    // Edge count over a fixed window, one edge of slack
    task automatic measure(input int unsigned exp);
        clr <= 1'b1;
        @(posedge CLK_SYS);
        clr <= 1'b0;
        repeat (512) @(posedge CLK_SYS);
        check((edges + 1 == exp || edges == exp + 1) ? exp : edges, exp);
    endtask
    function automatic logic usb_ok(int m, int p);
        return m >= 5 || (m == 1 && p < 2);
    endfunction
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        results;
    end
    initial begin
        repeat (10) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        void'($urandom(18));
        rchk(8'h00, 32'h0, RESP_OKAY);
        rchk(8'h04, 32'h0, RESP_OKAY);
        rchk(8'h08, 32'h26, RESP_OKAY);
        rchk(8'h0C, 32'h0, RESP_SLVERR);
        wr(8'h0C, 32'hFFFFFFFF, RESP_SLVERR);
        wr(8'h08, 32'hFFFFFFFF, RESP_OKAY);
        rchk(8'h08, 32'h26, RESP_OKAY);
        wr(8'h00, 32'hFFFFFFFF, RESP_OKAY);
        rchk(8'h00, 32'h0000BF00, RESP_OKAY);
        check(REF_CLOCK_PIN_OE, 1);
        wr(8'h00, 32'h0, RESP_OKAY);
        repeat (3) @(posedge CLK_SYS);
        check({REF_CLOCK_PIN_OE, REF_CLOCK_PIN}, 0);
        wr(8'h04, 32'hFFFFFFFF, RESP_OKAY);
        rchk(8'h04, 32'h003F0377, RESP_OKAY);
        check({FRC_SELF_TUNE_EN, FRC_TUNE}, 32'h7F);
        // Every mode against postscaler codes 0 to 2
        for (int m = 0; m < 8; m++) begin
            for (int p = 0; p < 3; p++) begin
                wr(8'h04, {25'h0, 3'(p), 1'b0, 3'(m)}, RESP_OKAY);
                repeat (3) @(posedge CLK_SYS);
                check(USB_CLOCK_EN, usb_ok(m, p));
                check(HALF_RATE_CLOCK_OUT_PIN_OE, m inside {0, 1, 2, 5});
            end
        end
        // Random divider, source and mode, with clock switches between
        for (int i = 0; i < 8; i++) begin
            code = (i == 0) ? 0 : $urandom % 4;
            sel = $urandom % 2;
            mode = ($urandom % 2) ? 2 : 0;
            wr(8'h04, {29'h0, 3'(mode)}, RESP_OKAY);
            wr(8'h00, {16'h0, 3'b100, 1'(sel), 4'(code), 8'h00}, RESP_OKAY);
            measure(512 / (((sel == 1 || mode == 2) ? 8 : 4) << code));
        end
        // Sleep with each mix of run-in-sleep, source and keep bits
        for (int i = 0; i < 8; i++) begin
            mode = ($urandom % 2) ? 3 : 0;
            wr(8'h04, {23'h0, i[2], 5'h0, 3'(mode)}, RESP_OKAY);
            wr(8'h00, {16'h0, 2'b10, i[1], i[0], 12'h000}, RESP_OKAY);
            SLEEP_REQ <= 1'b1;
            repeat (6) @(posedge CLK_SYS);
            check(PRIMARY_OSC_EN, mode == 3 || i[2] == 1);
            check(SYS_CLOCK_RUN, 0);
            check(FAST_RC_OSC_EN, 0);
            measure((i[0] && i[1] && (mode == 3 || i[2] == 1)) ? 64 : 0);
            rchk(8'h08, {27'h0, 1'b1, i[0] && i[1] && (mode == 3 || i[2] == 1), mode == 3 || i[2] == 1, 2'b00},
                RESP_OKAY);
            SLEEP_REQ <= 1'b0;
            repeat (6) @(posedge CLK_SYS);
        end
        results;
    end
endmodule
bind refclk_top refclk_sva chk (.*);
`default_nettype wire
